/* design/pci_status_pkg.sv */
// pci_status_pkg: register map, field positions, reset values and counts
// for the configuration status flags and the power-data readout.
// assumes registers are reached over a 32-bit AXI4-Lite slave port.
package pci_status_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_STATUS = 8'h06;
	localparam logic [7:0] IDX_MASK = 8'h40;
	localparam logic [7:0] IDX_PM_CTRL = 8'h55;
	localparam logic [7:0] IDX_POWER = 8'h57;
	localparam int MAP_ADDR_W = 10;
	localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
	localparam logic [9:0] ADDR_MASK = {IDX_MASK, 2'b00};
	localparam logic [9:0] ADDR_PM_CTRL = {IDX_PM_CTRL, 2'b00};
	localparam logic [9:0] ADDR_POWER = {IDX_POWER, 2'b00};

	// status word layout
	localparam int BIT_INIT_PERR = 8;
	localparam int BIT_SPEED_LO = 9;
	localparam int BIT_SENT_TA = 11;
	localparam int BIT_GOT_TA = 12;
	localparam int BIT_GOT_MA = 13;
	localparam int BIT_SERR_SENT = 14;
	localparam int BIT_PERR_SEEN = 15;
	localparam logic [1:0] SELECT_RESPONSE_SPEED = 2'h1;
	localparam logic [15:0] FLAG_MASK = 16'hF900;
	localparam int NUM_FLAGS = 6;

	// flag bank order: bank index -> status bit
	localparam int FIDX_INIT_PERR = 0;
	localparam int FIDX_SENT_TA = 1;
	localparam int FIDX_GOT_TA = 2;
	localparam int FIDX_GOT_MA = 3;
	localparam int FIDX_SERR_SENT = 4;
	localparam int FIDX_PERR_SEEN = 5;

	// power_mgmt_control select and scale fields
	localparam int PM_SEL_LO = 0;
	localparam int PM_SEL_W = 4;
	localparam int PM_SCALE_LO = 4;
	localparam int PM_SCALE_W = 2;
	localparam logic [5:0] PM_CTRL_RESET = 6'h00;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam int NUM_POWER_STATES = 8;
	localparam logic [7:0] POWER_DATA_RESET = 8'h00;

	// perr# is sampled this many clocks after a split-response write data phase
	localparam int PERR_DELAY = 3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_RESP = 2'b10
	} wr_state_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_RESP = 2'b10
	} rd_state_t;

endpackage

/* design/pci_status_power.sv */
// pci_status_power: upper configuration status flags, interrupt mask,
// power_mgmt_control select/scale fields and the power-data readout,
// all behind an AXI4-Lite slave.
// assumes bus-side event inputs are one-clock pulses on core_clk_i.
//
// Contract
// [RQ1] The status word always shows select_response_speed as 0x1 (medium).
// [RQ2] Ending a transaction as target with target-abort sets bit 11.
// [RQ3] A master transaction ended by target-abort sets bit 12.
// [RQ4] A master transaction ended by master-abort sets bit 13.
// [RQ5] Asserting the system error signal sets bit 14.
// [RQ6] Any detected parity error sets bit 15, whatever parity response says.
// [RQ7] In PCI-X mode, perr three clocks after a split-response write phase sets bit 8.
// [RQ8] In PCI-X mode, a parity error in split completion data or message sets bit 8.
// [RQ9] In PCI-X mode, a split completion message reporting a write parity error sets bit 8.
// [RQ10] An 8-bit read-only power value sits at index 0x57; software applies the scale.
// [RQ11] Each read of the power value follows the select field at that moment.
// [RQ12] Select 0x0 to 0x7 returns that state's figure; 0x8 and up read zero.
// [RQ13] Error flags clear on reset and stay set until reset or a software clear.
`timescale 1ns/1ps
module pci_status_power
	import pci_status_pkg::*;
#(
	parameter int AXI_ADDR_W = 12,
	parameter logic [63:0] POWER_FIGURES = 64'h0000000000000000
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic pcix_mode_i,
	input wire logic target_abort_sent_i,
	input wire logic target_abort_got_i,
	input wire logic master_abort_got_i,
	input wire logic serr_asserted_i,
	input wire logic parity_error_i,
	input wire logic master_perr_seen_i,
	input wire logic parity_response_en_i,
	input wire logic split_write_phase_i,
	input wire logic perr_i,
	input wire logic split_cpl_parity_err_i,
	input wire logic split_msg_write_perr_i,
	output logic [PM_SEL_W-1:0] power_select_o,
	output logic [PM_SCALE_W-1:0] power_scale_o,
	output logic irq_o
);

	initial
	begin
		if (AXI_ADDR_W < MAP_ADDR_W)
			$error("address width too small for the register map");
	end

	wr_state_t wr_state_reg, wr_state_next;
	rd_state_t rd_state_reg, rd_state_next;
	logic aw_held_reg, aw_held_next;
	logic w_held_reg, w_held_next;
	logic [AXI_ADDR_W-1:0] aw_addr_reg, aw_addr_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0] w_strb_reg, w_strb_next;
	logic [1:0] bresp_reg, bresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [15:0] mask_reg, mask_next;
	logic [5:0] pm_ctrl_reg, pm_ctrl_next;
	logic irq_reg, irq_next;
	logic aw_fire, w_fire, ar_fire, do_write;
	logic [AXI_ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [NUM_FLAGS-1:0] flag_set, flag_clr, flags;
	logic [15:0] status_word;
	logic [7:0] power_value;
	logic split_perr_hit;

	// handshakes: one write and one read in flight at most
	assign s_axi_awready_o = (wr_state_reg == WR_IDLE) && !aw_held_reg;
	assign s_axi_wready_o = (wr_state_reg == WR_IDLE) && !w_held_reg;
	assign s_axi_bvalid_o = (wr_state_reg == WR_RESP);
	assign s_axi_bresp_o = bresp_reg;
	assign s_axi_arready_o = (rd_state_reg == RD_IDLE);
	assign s_axi_rvalid_o = (rd_state_reg == RD_RESP);
	assign s_axi_rdata_o = rdata_reg;
	assign s_axi_rresp_o = rresp_reg;
	assign aw_fire = s_axi_awvalid_i && s_axi_awready_o;
	assign w_fire = s_axi_wvalid_i && s_axi_wready_o;
	assign ar_fire = s_axi_arvalid_i && s_axi_arready_o;

	// address and data may arrive in either order; the write happens once both are in
	assign wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr_i;
	assign wr_data = w_held_reg ? w_data_reg : s_axi_wdata_i;
	assign wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb_i;
	assign do_write = (wr_state_reg == WR_IDLE) && (aw_held_reg || aw_fire)
		&& (w_held_reg || w_fire);

	// status word with the fixed response-speed code
	always_comb
	begin
		status_word = 16'h0000;
		status_word[BIT_INIT_PERR] = flags[FIDX_INIT_PERR];
		status_word[BIT_SPEED_LO +: 2] = SELECT_RESPONSE_SPEED; // [RQ1]
		status_word[BIT_SENT_TA] = flags[FIDX_SENT_TA];
		status_word[BIT_GOT_TA] = flags[FIDX_GOT_TA];
		status_word[BIT_GOT_MA] = flags[FIDX_GOT_MA];
		status_word[BIT_SERR_SENT] = flags[FIDX_SERR_SENT];
		status_word[BIT_PERR_SEEN] = flags[FIDX_PERR_SEEN];
	end

	// power figure picked by the live select field; reserved codes read zero
	always_comb
	begin
		power_value = POWER_DATA_RESET;
		if (power_select_o < NUM_POWER_STATES) // [RQ12]
			power_value = POWER_FIGURES[{power_select_o[2:0], 3'b000} +: 8]; // [RQ11]
	end

	assign power_select_o = pm_ctrl_reg[PM_SEL_LO +: PM_SEL_W];
	assign power_scale_o = pm_ctrl_reg[PM_SCALE_LO +: PM_SCALE_W];

	split_perr_watch #(
		.DELAY(PERR_DELAY)
	) u_perr_watch (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.data_phase_i(split_write_phase_i & pcix_mode_i),
		.perr_i(perr_i),
		.hit_o(split_perr_hit)
	);

	// event sources for the sticky flags
	always_comb
	begin
		flag_set = '0;
		flag_set[FIDX_SENT_TA] = target_abort_sent_i; // [RQ2]
		flag_set[FIDX_GOT_TA] = target_abort_got_i; // [RQ3]
		flag_set[FIDX_GOT_MA] = master_abort_got_i; // [RQ4]
		flag_set[FIDX_SERR_SENT] = serr_asserted_i; // [RQ5]
		flag_set[FIDX_PERR_SEEN] = parity_error_i; // [RQ6]
		// conventional mode keeps the parity-response gate; PCI-X uses split terms
		flag_set[FIDX_INIT_PERR] = (!pcix_mode_i && master_perr_seen_i && parity_response_en_i)
			|| split_perr_hit // [RQ7]
			|| (pcix_mode_i && split_cpl_parity_err_i) // [RQ8]
			|| (pcix_mode_i && split_msg_write_perr_i); // [RQ9]
	end

	// write-one-to-clear on the high status byte and bit 8
	always_comb
	begin
		flag_clr = '0;
		if (do_write && wr_addr == AXI_ADDR_W'(ADDR_STATUS) && wr_strb[1])
		begin
			flag_clr[FIDX_INIT_PERR] = wr_data[BIT_INIT_PERR];
			flag_clr[FIDX_SENT_TA] = wr_data[BIT_SENT_TA];
			flag_clr[FIDX_GOT_TA] = wr_data[BIT_GOT_TA];
			flag_clr[FIDX_GOT_MA] = wr_data[BIT_GOT_MA];
			flag_clr[FIDX_SERR_SENT] = wr_data[BIT_SERR_SENT];
			flag_clr[FIDX_PERR_SEEN] = wr_data[BIT_PERR_SEEN];
		end
	end

	sticky_flag_bank #(
		.WIDTH(NUM_FLAGS)
	) u_flags (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.set_i(flag_set),
		.clr_i(flag_clr), // [RQ13]
		.flags_o(flags)
	);

	// write channel: hold whichever half came first, then answer
	always_comb
	begin
		wr_state_next = wr_state_reg;
		aw_held_next = aw_held_reg;
		w_held_next = w_held_reg;
		aw_addr_next = aw_addr_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bresp_next = bresp_reg;
		mask_next = mask_reg;
		pm_ctrl_next = pm_ctrl_reg;
		case (wr_state_reg)
			WR_IDLE:
			begin
				if (aw_fire)
				begin
					aw_held_next = 1'b1;
					aw_addr_next = s_axi_awaddr_i;
				end
				if (w_fire)
				begin
					w_held_next = 1'b1;
					w_data_next = s_axi_wdata_i;
					w_strb_next = s_axi_wstrb_i;
				end
				if (do_write)
				begin
					wr_state_next = WR_RESP;
					bresp_next = RESP_OKAY;
					// read-only power value and status writes answer okay
					if (wr_addr == AXI_ADDR_W'(ADDR_STATUS))
						bresp_next = RESP_OKAY;
					else if (wr_addr == AXI_ADDR_W'(ADDR_MASK))
					begin
						if (wr_strb[0])
							mask_next[7:0] = wr_data[7:0] & FLAG_MASK[7:0];
						if (wr_strb[1])
							mask_next[15:8] = wr_data[15:8] & FLAG_MASK[15:8];
					end
					else if (wr_addr == AXI_ADDR_W'(ADDR_PM_CTRL))
					begin
						if (wr_strb[0])
							pm_ctrl_next = wr_data[5:0];
					end
					else if (wr_addr == AXI_ADDR_W'(ADDR_POWER))
						bresp_next = RESP_OKAY;
					else
						bresp_next = RESP_SLVERR;
				end
			end
			WR_RESP:
			begin
				if (s_axi_bready_i)
				begin
					wr_state_next = WR_IDLE;
					aw_held_next = 1'b0;
					w_held_next = 1'b0;
				end
			end
			default:
				wr_state_next = WR_IDLE;
		endcase
	end

	// read channel: data is sampled on the address edge, so it reflects that moment
	always_comb
	begin
		rd_state_next = rd_state_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		case (rd_state_reg)
			RD_IDLE:
			begin
				if (ar_fire)
				begin
					rd_state_next = RD_RESP;
					rresp_next = RESP_OKAY;
					if (s_axi_araddr_i == AXI_ADDR_W'(ADDR_STATUS))
						rdata_next = {16'h0000, status_word};
					else if (s_axi_araddr_i == AXI_ADDR_W'(ADDR_MASK))
						rdata_next = {16'h0000, mask_reg};
					else if (s_axi_araddr_i == AXI_ADDR_W'(ADDR_PM_CTRL))
						rdata_next = {26'h0, pm_ctrl_reg};
					else if (s_axi_araddr_i == AXI_ADDR_W'(ADDR_POWER))
						rdata_next = {24'h000000, power_value}; // [RQ10]
					else
					begin
						rdata_next = 32'h00000000;
						rresp_next = RESP_SLVERR;
					end
				end
			end
			RD_RESP:
			begin
				if (s_axi_rready_i)
					rd_state_next = RD_IDLE;
			end
			default:
				rd_state_next = RD_IDLE;
		endcase
	end

	// interrupt: level while any unmasked flag is set
	always_comb
	begin
		irq_next = |(status_word & mask_reg & FLAG_MASK);
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wr_state_reg <= WR_IDLE;
			rd_state_reg <= RD_IDLE;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			bresp_reg <= RESP_OKAY;
			rdata_reg <= 32'h00000000;
			rresp_reg <= RESP_OKAY;
			mask_reg <= MASK_RESET;
			pm_ctrl_reg <= PM_CTRL_RESET;
			irq_reg <= 1'b0;
		end
		else
		begin
			wr_state_reg <= wr_state_next;
			rd_state_reg <= rd_state_next;
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			aw_addr_reg <= aw_addr_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			bresp_reg <= bresp_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
			mask_reg <= mask_next;
			pm_ctrl_reg <= pm_ctrl_next;
			irq_reg <= irq_next;
		end
	end

	assign irq_o = irq_reg;

	// checks on flag setting, readout and interrupt timing
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	sequence split_phase_s;
		pcix_mode_i && split_write_phase_i;
	endsequence

	sequence late_perr_s;
		split_phase_s ##3 perr_i;
	endsequence

	speed_code_read_a: assert property (ar_fire && s_axi_araddr_i == AXI_ADDR_W'(ADDR_STATUS) |=> s_axi_rdata_o[10:9] == 2'h1) // [RQ1]
		else $error("response speed code not 0x1");
	sent_abort_set_a: assert property (target_abort_sent_i |=> flags[FIDX_SENT_TA]) // [RQ2]
		else $error("sent target abort flag not set");
	got_abort_set_a: assert property (target_abort_got_i |=> flags[FIDX_GOT_TA]) // [RQ3]
		else $error("received target abort flag not set");
	master_abort_set_a: assert property (master_abort_got_i |=> flags[FIDX_GOT_MA]) // [RQ4]
		else $error("received master abort flag not set");
	serr_flag_set_a: assert property (serr_asserted_i |=> flags[FIDX_SERR_SENT]) // [RQ5]
		else $error("system error flag not set");
	parity_seen_a: assert property (parity_error_i |=> status_word[BIT_PERR_SEEN]) // [RQ6]
		else $error("detected parity flag not set");
	split_perr_a: assert property (late_perr_s |=> flags[FIDX_INIT_PERR]) // [RQ7]
		else $error("late perr on split write missed");
	split_cpl_perr_a: assert property (pcix_mode_i && split_cpl_parity_err_i |=> flags[FIDX_INIT_PERR]) // [RQ8]
		else $error("split completion parity error missed");
	split_msg_perr_a: assert property (pcix_mode_i && split_msg_write_perr_i |=> flags[FIDX_INIT_PERR]) // [RQ9]
		else $error("split message parity error missed");
	power_read_a: assert property (ar_fire && s_axi_araddr_i == AXI_ADDR_W'(ADDR_POWER) && power_select_o < 4'h8 |=> s_axi_rdata_o == {24'h000000, POWER_FIGURES[{$past(power_select_o[2:0]), 3'b000} +: 8]}) // [RQ11]
		else $error("power readout does not follow select");
	reserved_select_a: assert property (ar_fire && s_axi_araddr_i == AXI_ADDR_W'(ADDR_POWER) && power_select_o >= 4'h8 |=> s_axi_rdata_o == 32'h00000000) // [RQ12]
		else $error("reserved select did not read zero");
	flag_hold_a: assert property (flags[FIDX_GOT_MA] && !flag_clr[FIDX_GOT_MA] |=> flags[FIDX_GOT_MA]) // [RQ13]
		else $error("abort flag dropped without clear");
	irq_level_a: assert property (irq_o == $past(|(status_word & mask_reg)))
		else $error("interrupt level wrong");

endmodule

/* design/split_perr_watch.sv */
// split_perr_watch: flags perr# seen a fixed number of clocks after a
// data phase of a write that ended with split response.
// assumes both inputs are synchronous to core_clk_i.
`timescale 1ns/1ps
module split_perr_watch #(
	parameter int DELAY = 3
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic data_phase_i,
	input wire logic perr_i,
	output logic hit_o
);

	initial
	begin
		if (DELAY < 2)
			$error("split_perr_watch needs a delay of two clocks or more");
	end

	logic [DELAY-1:0] pipe_reg;
	logic [DELAY-1:0] pipe_next;

	// one bit per outstanding data phase, so back-to-back phases all count
	always_comb
	begin
		pipe_next = {pipe_reg[DELAY-2:0], data_phase_i};
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			pipe_reg <= '0;
		else
			pipe_reg <= pipe_next;
	end

	assign hit_o = pipe_reg[DELAY-1] & perr_i;

endmodule

/* design/sticky_flag_bank.sv */
// sticky_flag_bank: a row of set/clear flags, one flop per bit.
// assumes set and clear are single-clock requests on core_clk_i.
`timescale 1ns/1ps
module sticky_flag_bank #(
	parameter int WIDTH = 6
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] set_i,
	input wire logic [WIDTH-1:0] clr_i,
	output logic [WIDTH-1:0] flags_o
);

	initial
	begin
		if (WIDTH < 1)
			$error("sticky_flag_bank needs at least one flag");
	end

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : gen_flag
			logic flag_reg;
			logic flag_next;
			// a set arriving with the clear wins, so no event is dropped
			always_comb
			begin
				flag_next = flag_reg;
				if (clr_i[g])
					flag_next = 1'b0;
				if (set_i[g])
					flag_next = 1'b1;
			end
			always_ff @(posedge core_clk_i or posedge rst_i)
			begin
				if (rst_i)
					flag_reg <= 1'b0;
				else
					flag_reg <= flag_next;
			end
			assign flags_o[g] = flag_reg;
		end
	endgenerate

endmodule

/* verification/bus_event_source.sv */
// bus_event_source: far-side stand-in for the pci bus, turning one-hot
// requests from the bench into one-clock event pulses.
// assumes req_i is held for exactly one clock per event.
`timescale 1ns/1ps
module bus_event_source (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [8:0] req_i,
	output logic [8:0] ev_o,
	output logic perr_o
);
	logic [2:0] pipe_reg;
	logic [2:0] pipe_next;
	// pulses last one clock so a flag that only follows its input has dropped again by the later status read
	always_comb
	begin
		pipe_next = {pipe_reg[1:0], ev_o[6]};
	end
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ev_o <= 9'h000;
			pipe_reg <= 3'h0;
		end
		else
		begin
			ev_o <= req_i;
			pipe_reg <= pipe_next;
		end
	end
	// perr comes three clocks after the split write data phase
	assign perr_o = pipe_reg[2];
endmodule

/* verification/pci_status_power_tb.sv */
// pci_status_power_tb: self-checking bench for status flags, interrupt
// and power readout; assumes bus_event_source provides the bus events.
`timescale 1ns/1ps
module pci_status_power_tb;
	import pci_status_pkg::*;
	localparam logic [63:0] FIGS = 64'hA1B2C3D4E5F60718;
	localparam logic [11:0] A_ST = {2'h0, ADDR_STATUS};
	localparam logic [11:0] A_PW = {2'h0, ADDR_POWER};
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic pcix = 1'b0;
	logic per_en = 1'b0;
	logic [8:0] req = 9'h000;
	logic awready, wready, bvalid, arready, rvalid, perr, irq;
	logic [1:0] bresp, rresp, scale, sc;
	logic [31:0] rdata, v;
	logic [3:0] sel;
	logic [8:0] ev;
	integer miscompares = 0;
	integer n_tests = 0;
	integer seed;
	int off;
	always #4 core_clk_i = ~core_clk_i;
	bus_event_source partner (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req), .ev_o(ev),
		.perr_o(perr));
	pci_status_power #(.POWER_FIGURES(FIGS)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .pcix_mode_i(pcix),
		.target_abort_sent_i(ev[0]), .target_abort_got_i(ev[1]), .master_abort_got_i(ev[2]),
		.serr_asserted_i(ev[3]), .parity_error_i(ev[4]), .master_perr_seen_i(ev[5]),
		.parity_response_en_i(per_en), .split_write_phase_i(ev[6]), .perr_i(perr),
		.split_cpl_parity_err_i(ev[7]), .split_msg_write_perr_i(ev[8]),
		.power_select_o(sel), .power_scale_o(scale), .irq_o(irq));
	task automatic summarize();
		$display("comparisons %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	// a handshake that never completes is counted and ends the run
	task automatic give_up();
		chk("bus_answer", 32'h00000001, 32'h00000000);
		summarize();
	endtask
	// write: aw and w offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		bit done;
		n = 0;
		done = 0;
		@(posedge core_clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done && n < 100)
		begin
			@(posedge core_clk_i);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
			begin
				done = 1;
				bready <= 1'b0;
				chk("bresp", {30'h0, er}, {30'h0, bresp});
			end
		end
		if (!done)
			give_up();
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
		int n;
		bit done;
		n = 0;
		done = 0;
		@(posedge core_clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done && n < 100)
		begin
			@(posedge core_clk_i);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
			begin
				done = 1;
				d = rdata;
				rready <= 1'b0;
				chk("rresp", {30'h0, er}, {30'h0, rresp});
			end
		end
		if (!done)
			give_up();
	endtask
	task automatic pulse(input int k);
		@(posedge core_clk_i);
		req <= 9'h001 << k;
		@(posedge core_clk_i);
		req <= 9'h000;
	endtask
	function automatic int bit_of(input int k);
		bit_of = (k < 5) ? 11 + k : 8;
	endfunction
	function automatic logic [31:0] exp_status(input int b);
		exp_status = {21'h0, SELECT_RESPONSE_SPEED, 9'h000};
		if (b >= 0)
			exp_status[b] = 1'b1;
	endfunction
	// entries past the eighth state read as zero
	function automatic logic [31:0] exp_power(input logic [3:0] s);
		exp_power = 32'h00000000;
		if (s < 4'h8)
			exp_power[7:0] = FIGS[8*s+:8];
	endfunction
	initial
	begin
		seed = 32'hCD5DD9AD;
		repeat (4) @(posedge core_clk_i);
		rst_i <= 1'b0;
		rd(A_ST, v, RESP_OKAY);
		chk("status_reset", exp_status(-1), v);
		// each event kind sets its flag, held through a random idle time
		for (int k = 0; k < 9; k++)
		begin
			pcix <= (k >= 6);
			per_en <= (k != 4);
			pulse(k);
			repeat (4 + ($unsigned($random(seed)) % 8)) @(posedge core_clk_i);
			rd(A_ST, v, RESP_OKAY);
			chk("status_set", exp_status(bit_of(k)), v);
			wr(A_ST, 32'h00000001 << bit_of(k), RESP_OKAY);
			rd(A_ST, v, RESP_OKAY);
			chk("status_clr", exp_status(-1), v);
		end
		// unmasked flag raises the interrupt, masked flag does not
		wr({2'h0, ADDR_MASK}, 32'h00000800, RESP_OKAY);
		pulse(0);
		repeat (4) @(posedge core_clk_i);
		chk("irq_set", 32'h00000001, {31'h0, irq});
		wr(A_ST, 32'h00000800, RESP_OKAY);
		repeat (2) @(posedge core_clk_i);
		chk("irq_clr", 32'h00000000, {31'h0, irq});
		pulse(1);
		repeat (4) @(posedge core_clk_i);
		chk("irq_masked", 32'h00000000, {31'h0, irq});
		// a flag still set is wiped by a reset in mid-run
		@(posedge core_clk_i);
		rst_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		rst_i <= 1'b0;
		rd(A_ST, v, RESP_OKAY);
		chk("status_rst", exp_status(-1), v);
		// every select code from a random start, with a random scale
		off = $unsigned($random(seed)) % 16;
		for (int i = 0; i < 16; i++)
		begin
			sc = 2'($random(seed));
			wr({2'h0, ADDR_PM_CTRL}, {26'h0, sc, 4'((i + off) % 16)}, RESP_OKAY);
			chk("select", 32'((i + off) % 16), {28'h0, sel});
			chk("scale", {30'h0, sc}, {30'h0, scale});
			rd(A_PW, v, RESP_OKAY);
			chk("power", exp_power(4'((i + off) % 16)), v);
		end
		// the readout ignores writes; unmapped places answer with an error
		wr(A_PW, 32'h000000FF, RESP_OKAY);
		rd(A_PW, v, RESP_OKAY);
		chk("power_ro", exp_power(sel), v);
		rd(12'h3FC, v, RESP_SLVERR);
		chk("unmapped", 32'h00000000, v);
		summarize();
	end
endmodule
